// [hdl/dha_pkg.sv]
// Constants, register map and state types for the diskette head access block.
// Assumes a 20 MHz system clock and an AXI4-Lite master with 32-bit data.
// Notes on behaviour
// (R1) After warm-up, index pulses arrive once per revolution, every 166.6 ms.
// (R2) Index pulses are ignored until ten seconds after drive power-on.
// (R3) Control write with head-engage set drives the head load line.
// (R4) Read data counts only while activate is high; earlier data is dropped.
// (R5) Each step request moves the head one track; two bits pick direction.
// (R6) One step is one quarter turn of the stepper, one track of travel.
// (R7) A step drives two adjacent phase lines together for at least 50 ms.
// (R8) Track lines stay energised 150 ms (50 travel, 100 stabilise) before reading.
// (R9) Software should release head load soon after the last operation.
// (R10) Head load is energised throughout any read in progress.
// (R11) While reading, the phase tag pulses low once per 64 us word.
// (R12) Software switches the drive motor on before any diskette operation.
// (R13) Exactly one index pulse per revolution is forwarded to the controller.
// (R14) Software waits 60 ms after engaging the head before starting a read.
package dha_pkg;
	localparam int CLK_HZ          = 20_000_000;
	localparam int WARMUP_S        = 10;
	localparam int INDEX_TENTH_MS  = 1666;
	localparam int TRAVEL_MS       = 50;
	localparam int STABILISE_MS    = 100;
	localparam int HEAD_SETTLE_MS  = 60;
	localparam int TAG_US          = 64;
	localparam int WORD_BITS       = 16;
	localparam int WARMUP_CYC      = WARMUP_S * CLK_HZ;
	localparam int INDEX_CYC       = INDEX_TENTH_MS * (CLK_HZ / 10_000);
	localparam int HOLD_CYC        = (TRAVEL_MS + STABILISE_MS) * (CLK_HZ / 1000);
	localparam int SETTLE_CYC      = HEAD_SETTLE_MS * (CLK_HZ / 1000);
	localparam int TAG_CYC         = TAG_US * (CLK_HZ / 1_000_000);
	localparam int BIT_CYC         = TAG_CYC / WORD_BITS;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA   = 8'h08;
	localparam logic [7:0] ADDR_PERIOD = 8'h0C;
	localparam int CTRL_MOTOR      = 0;
	localparam int CTRL_ENGAGE     = 1;
	localparam int CTRL_DIR_LO     = 2;
	localparam int CTRL_READ       = 4;
	localparam int CTRL_CLRFAULT   = 5;
	localparam logic [1:0] DIR_UP   = 2'h1;
	localparam logic [1:0] DIR_DOWN = 2'h2;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_MOVE = 1'b1} dha_step_type;
	typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_ARMED = 2'b01, RD_ACTIVE = 2'b10} dha_read_type;
endpackage : dha_pkg

// [hdl/dha_head_access.sv]
// Head load, stepper sequencing, index tracking and read word framing.
// Assumes drive pins are asynchronous; registers reached over AXI4-Lite.
`timescale 1ns/1ns
module dha_head_access #(
	parameter int CW         = 28,
	parameter int WARMUP     = dha_pkg::WARMUP_CYC,
	parameter int INDEX_PER  = dha_pkg::INDEX_CYC,
	parameter int HOLD       = dha_pkg::HOLD_CYC,
	parameter int SETTLE     = dha_pkg::SETTLE_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        indexPin,
	input  wire logic        readBitPin,
	output logic             motorOn,
	output logic             headLoad,
	output logic [3:0]       accessPhase,
	output logic             serializer_phase_tagN
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] idxSync;
	logic [2:0] rdSync;
	logic       idxLevel;
	logic       idxLevelQ;
	logic       rdLevel;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			idxSync   <= 3'h0;
			rdSync    <= 3'h0;
			idxLevel  <= 1'b0;
			idxLevelQ <= 1'b0;
			rdLevel   <= 1'b0;
		end else begin
			idxSync   <= {idxSync[1:0], indexPin};
			rdSync    <= {rdSync[1:0], readBitPin};
			// A change only counts once stages two and three agree
			if (idxSync[1] == idxSync[2])
				idxLevel <= idxSync[2];
			if (rdSync[1] == rdSync[2])
				rdLevel <= rdSync[2];
			idxLevelQ <= idxLevel;
		end
	end

	// ****************************************
	// Register file and AXI4-Lite slave
	// ****************************************
	logic [5:0]  ctrl;
	logic [7:0]  awAddr;
	logic [31:0] wData;
	logic        awHeld;
	logic        wHeld;
	logic        doWrite;
	logic        ctrlHit;
	logic        dataRead;
	logic        wordReady;
	logic        indexFault;
	logic [15:0] dataWord;
	logic [CW-1:0] period;
	logic [31:0] next_rdata;
	logic        next_rerr;
	logic        warmupDone;
	logic        headSettled;
	logic        stepBusy;
	logic        trackSettled;
	logic        reading;
	logic        activate;
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign doWrite  = awHeld && wHeld && !s_axi_bvalid;
	assign ctrlHit  = doWrite && awAddr == dha_pkg::ADDR_CTRL && s_axi_wstrb == 4'hF;
	assign dataRead = s_axi_arvalid && s_axi_arready && s_axi_araddr == dha_pkg::ADDR_DATA;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			awHeld       <= 1'b0;
			wHeld        <= 1'b0;
			awAddr       <= 8'h00;
			wData        <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= dha_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
			end
			if (doWrite) begin
				awHeld       <= 1'b0;
				wHeld        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr == dha_pkg::ADDR_CTRL) ? dha_pkg::RESP_OKAY : dha_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	always_comb begin
		next_rdata = 32'h0;
		next_rerr  = 1'b0;
		case (s_axi_araddr)
			dha_pkg::ADDR_CTRL:   next_rdata = {26'h0, ctrl};
			dha_pkg::ADDR_STATUS: next_rdata = {19'h0, wordReady, accessPhase, indexFault, activate,
				reading, trackSettled, stepBusy, warmupDone, headSettled, headLoad};
			dha_pkg::ADDR_DATA:   next_rdata = {16'h0, dataWord};
			dha_pkg::ADDR_PERIOD: next_rdata = {{(32-CW){1'b0}}, period};
			default:              next_rerr  = 1'b1;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= dha_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rerr ? dha_pkg::RESP_SLVERR : dha_pkg::RESP_OKAY;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************
	// Control register
	// ****************************************
	logic readDone;
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			ctrl <= dha_pkg::CTRL_RESET;
		else if (ctrlHit)
			ctrl <= wData[5:0];
		else if (readDone)
			ctrl[dha_pkg::CTRL_READ] <= 1'b0;
		else
			ctrl[dha_pkg::CTRL_CLRFAULT] <= 1'b0;
	end
	assign motorOn = ctrl[dha_pkg::CTRL_MOTOR];

	// ****************************************
	// Warm-up, index tracking, head settle
	// ****************************************
	logic [CW-1:0] warmCnt;
	logic [CW-1:0] idxCnt;
	logic [CW-1:0] headCnt;
	logic          indexValid;
	// Warm-up restarts whenever the motor is switched off
	always_ff @(posedge clk_sys) begin
		if (!resetn || !motorOn)
			warmCnt <= '0;
		else if (!warmupDone)
			warmCnt <= warmCnt + CW'(1);
	end
	assign warmupDone = warmCnt == CW'(WARMUP);                                          // R2
	assign indexValid = idxLevel && !idxLevelQ && warmupDone;                            // R2 R13
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			idxCnt     <= '0;
			period     <= '0;
			indexFault <= 1'b0;
		end else begin
			if (indexValid) begin
				idxCnt <= '0;
				period <= idxCnt + CW'(1);
			end else if (warmupDone && idxCnt != CW'(2 * INDEX_PER))
				idxCnt <= idxCnt + CW'(1);
			// A missing revolution sets the fault; a set outranks the clear
			if (warmupDone && idxCnt == CW'(2 * INDEX_PER - 1))                             // R1
				indexFault <= 1'b1;
			else if (ctrl[dha_pkg::CTRL_CLRFAULT])
				indexFault <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn || !headLoad)
			headCnt <= '0;
		else if (!headSettled)
			headCnt <= headCnt + CW'(1);
	end
	assign headSettled = headCnt == CW'(SETTLE);

	// ****************************************
	// Stepper sequencing
	// ****************************************
	dha_pkg::dha_step_type stepState;
	logic [1:0]    pos;
	logic [1:0]    oldPos;
	logic [7:0]    track;
	logic [CW-1:0] stepCnt;
	logic [1:0]    reqDir;
	assign reqDir   = wData[dha_pkg::CTRL_DIR_LO +: 2];
	assign stepBusy = stepState == dha_pkg::ST_MOVE;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			stepState    <= dha_pkg::ST_IDLE;
			pos          <= 2'h0;
			oldPos       <= 2'h0;
			track        <= 8'h00;
			stepCnt      <= '0;
			trackSettled <= 1'b0;
		end else begin
			case (stepState)
				dha_pkg::ST_IDLE: begin
					// A request during a move is dropped, never queued
					if (ctrlHit && (reqDir == dha_pkg::DIR_UP || reqDir == dha_pkg::DIR_DOWN)) begin
						oldPos       <= pos;
						pos          <= (reqDir == dha_pkg::DIR_UP) ? pos + 2'h1 : pos - 2'h1;  // R5 R6
						track        <= (reqDir == dha_pkg::DIR_UP) ? track + 8'h01 : track - 8'h01;
						stepCnt      <= '0;
						trackSettled <= 1'b0;
						stepState    <= dha_pkg::ST_MOVE;
					end
				end
				dha_pkg::ST_MOVE: begin
					stepCnt <= stepCnt + CW'(1);
					if (stepCnt == CW'(HOLD - 1)) begin                                          // R7 R8
						trackSettled <= 1'b1;
						stepState    <= dha_pkg::ST_IDLE;
					end
				end
				default: stepState <= dha_pkg::ST_IDLE;
			endcase
		end
	end
	// Old and new adjacent lines overlap for the whole move
	assign accessPhase = (4'h1 << pos) | (stepBusy ? (4'h1 << oldPos) : 4'h0);           // R7

	// ****************************************
	// Read framing
	// ****************************************
	dha_pkg::dha_read_type rdState;
	logic [10:0] tagCnt;
	logic [6:0]  bitCnt;
	logic [15:0] shiftReg;
	logic        tagPulse;
	assign reading  = rdState != dha_pkg::RD_IDLE;
	assign activate = rdState == dha_pkg::RD_ACTIVE;
	assign readDone = activate && (indexValid || !ctrl[dha_pkg::CTRL_READ]);
	assign headLoad = ctrl[dha_pkg::CTRL_ENGAGE] || ctrl[dha_pkg::CTRL_READ] || reading; // R3 R10
	assign tagPulse = activate && tagCnt == 11'(dha_pkg::TAG_CYC - 1);
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			rdState <= dha_pkg::RD_IDLE;
		else begin
			case (rdState)
				dha_pkg::RD_IDLE:
					if (ctrl[dha_pkg::CTRL_READ] && trackSettled && !stepBusy && warmupDone)     // R8
						rdState <= dha_pkg::RD_ARMED;
				dha_pkg::RD_ARMED:
					if (!ctrl[dha_pkg::CTRL_READ])
						rdState <= dha_pkg::RD_IDLE;
					else if (indexValid)
						rdState <= dha_pkg::RD_ACTIVE;                                             // R4
				dha_pkg::RD_ACTIVE:
					if (readDone)
						rdState <= dha_pkg::RD_IDLE;
				default: rdState <= dha_pkg::RD_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn || !activate) begin
			tagCnt   <= 11'h000;
			bitCnt   <= 7'h00;
			shiftReg <= 16'h0000;                                                            // R4
		end else begin
			tagCnt <= tagPulse ? 11'h000 : tagCnt + 11'h001;
			if (bitCnt == 7'(dha_pkg::BIT_CYC - 1)) begin
				bitCnt   <= 7'h00;
				shiftReg <= {shiftReg[14:0], rdLevel};
			end else
				bitCnt <= bitCnt + 7'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			serializer_phase_tagN <= 1'b1;
			dataWord              <= 16'h0000;
			wordReady             <= 1'b0;
		end else begin
			serializer_phase_tagN <= !tagPulse;                                              // R11
			if (tagPulse)
				dataWord <= {shiftReg[14:0], rdLevel};
			// A new word outranks the read that clears the flag
			if (tagPulse)
				wordReady <= 1'b1;
			else if (dataRead)
				wordReady <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_warm_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
		(idxLevel && !idxLevelQ && !warmupDone) |-> ##1 rdState != dha_pkg::RD_ACTIVE || $past(activate))
		else $error("index accepted before warm-up");
	a_head_engage: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
		(ctrlHit && wData[dha_pkg::CTRL_ENGAGE]) |=> headLoad)
		else $error("head load not driven after engage");
	a_data_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
		$rose(activate) |-> $past(rdState) == dha_pkg::RD_ARMED && $past(indexValid))
		else $error("activate without index");
	a_one_track: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
		$rose(stepBusy) |-> (track - $past(track) == 8'h01 || $past(track) - track == 8'h01))
		else $error("step moved other than one track");
	a_quarter_turn: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
		$rose(stepBusy) |-> (pos - oldPos == 2'h1 || oldPos - pos == 2'h1))
		else $error("step not a quarter turn");
	a_phase_overlap: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
		stepBusy |-> $countones(accessPhase) == 2)
		else $error("two phase lines not energised during step");
	a_hold_time: assert property (@(posedge clk_sys) disable iff (!resetn) // R8
		$fell(stepBusy) |-> $past(stepCnt) == CW'(HOLD - 1) && trackSettled)
		else $error("track hold time wrong");
	a_read_load: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
		reading |-> headLoad)
		else $error("head not loaded while reading");
	a_tag_pulse: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
		$fell(serializer_phase_tagN) |=> serializer_phase_tagN [*8])
		else $error("phase tag pulse too long or too frequent");
	a_index_edge: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
		indexValid |=> !indexValid)
		else $error("index forwarded twice");
endmodule : dha_head_access

// [verification/dha_drive_model.sv]
// Behavioural diskette drive: index sensor, read head and stepper carriage.
// Assumes the bench clock; the disk turns only while the motor line is high.
`timescale 1ns/1ns
module dha_drive_model #(
	parameter int PER = 4000
) (
	input  wire logic         clk_sys,
	input  wire logic         motorOn,
	input  wire logic         headLoad,
	input  wire logic [3:0]   accessPhase,
	input  wire logic         stall,
	output logic              indexPin,
	output logic              readBitPin,
	output logic signed [7:0] track
);
	int         cnt = 0;
	logic [3:0] last = 4'h1;
	initial track = 8'sh00;
	initial readBitPin = 1'b0;
	// ****************************************
	// Index and read head
	// ****************************************
	always @(posedge clk_sys) begin
		if (motorOn && !stall)
			cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
	end
	assign indexPin = motorOn && !stall && cnt < 4;
	// Unloaded head gives noise, never a held level
	always @(posedge clk_sys) begin
		readBitPin <= headLoad ? 1'b1 : ~readBitPin;
	end
	// ****************************************
	// Carriage: a quarter turn is one track
	// ****************************************
	always @(posedge clk_sys) begin
		if ($countones(accessPhase) == 1 && accessPhase != last) begin
			if (accessPhase == {last[2:0], last[3]})
				track <= track + 8'sh01;
			else
				track <= track - 8'sh01;
			last <= accessPhase;
		end
	end
endmodule : dha_drive_model

// [verification/test_diskette_head_access.sv]
// Self-checking bench for the head access block over AXI4-Lite.
// Assumes shortened warm-up, revolution and hold counts set below.
`timescale 1ns/1ns
module test_diskette_head_access;
	localparam int          PER  = 4000;
	localparam int          HOLD = 50;
	localparam logic [31:0] BASE = 32'h0000_0003;
	logic              clk_sys = 1'b0;
	logic              resetn = 1'b0;
	logic [7:0]        s_axi_awaddr = 8'h00;
	logic [7:0]        s_axi_araddr = 8'h00;
	logic [31:0]       s_axi_wdata = 32'h0000_0000;
	logic [3:0]        s_axi_wstrb = 4'h0;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stall = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0]       s_axi_rdata, rd;
	logic              indexPin, readBitPin, motorOn, headLoad, serializer_phase_tagN;
	logic [3:0]        accessPhase;
	logic signed [7:0] track;
	logic [1:0]        dirs [3] = '{dha_pkg::DIR_UP, dha_pkg::DIR_DOWN, dha_pkg::DIR_DOWN};
	int                mismatches = 0, totalChecks = 0, pos = 0, np, cnt, n, t1, t2;
	always #25 clk_sys = ~clk_sys;
	dha_head_access #(.WARMUP(200), .INDEX_PER(PER), .HOLD(HOLD), .SETTLE(40)) u_dut (
		.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.indexPin(indexPin), .readBitPin(readBitPin), .motorOn(motorOn), .headLoad(headLoad),
		.accessPhase(accessPhase), .serializer_phase_tagN(serializer_phase_tagN)
	);
	dha_drive_model #(.PER(PER)) u_drive (
		.clk_sys(clk_sys), .motorOn(motorOn), .headLoad(headLoad), .accessPhase(accessPhase),
		.stall(stall), .indexPin(indexPin), .readBitPin(readBitPin), .track(track)
	);
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic awOk, wOk;
		awOk = 1'b0;
		wOk = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(awOk && wOk)) begin
			@(posedge clk_sys);
			if (!awOk && s_axi_awready) begin
				awOk = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wOk && s_axi_wready) begin
				wOk = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic close_out;
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		chk("motorOn", 32'h0, motorOn);
		chk("headLoad", 32'h0, headLoad);
		chk("tagN", 32'h1, serializer_phase_tagN);
		axi_rd(dha_pkg::ADDR_STATUS);
		chk("status", 32'h0000_0100, rd);
		axi_rd(8'h10);
		chk("unmapped rdata", 32'h0, rd);
		chk("unmapped rresp", dha_pkg::RESP_SLVERR, rsp);
		axi_wr(dha_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
		chk("readonly bresp", dha_pkg::RESP_SLVERR, rsp);
		$display("test reset and map finished");
		// Motor first, before any diskette operation
		axi_wr(dha_pkg::ADDR_CTRL, BASE);
		chk("motorOn", 32'h1, motorOn);
		chk("headLoad", 32'h1, headLoad);
		axi_rd(dha_pkg::ADDR_STATUS);
		chk("warmupDone early", 32'h0, rd[2]);
		$display("test engage finished");
		for (int i = 0; i < 3; i++) begin
			np = (dirs[i] == dha_pkg::DIR_UP) ? (pos + 1) % 4 : (pos + 3) % 4;
			axi_wr(dha_pkg::ADDR_CTRL, BASE | {28'h0, dirs[i], 2'h0});
			chk("phase pair", (1 << pos) | (1 << np), accessPhase);
			// Second request while moving must not stack a track
			axi_wr(dha_pkg::ADDR_CTRL, BASE | {28'h0, dirs[i], 2'h0});
			axi_rd(dha_pkg::ADDR_STATUS);
			chk("stepBusy", 32'h1, rd[3]);
			cnt = 0;
			while ($countones(accessPhase) == 2 && cnt < 1000) begin
				@(posedge clk_sys);
				cnt++;
			end
			chk("overlap span", 32'h1, cnt >= HOLD - 20 && cnt <= HOLD);
			pos = np;
			chk("phase rest", 1 << pos, accessPhase);
		end
		axi_rd(dha_pkg::ADDR_STATUS);
		chk("trackSettled", 32'h1, rd[4]);
		chk("track", 32'h0000_00FF, {24'h0, track});
		$display("test stepping finished");
		repeat (2 * PER + 10) @(posedge clk_sys);
		axi_rd(dha_pkg::ADDR_STATUS);
		chk("warmupDone", 32'h1, rd[2]);
		chk("indexFault", 32'h0, rd[7]);
		axi_rd(dha_pkg::ADDR_PERIOD);
		chk("period", PER, rd);
		stall <= 1'b1;
		repeat (2 * PER + 20) @(posedge clk_sys);
		axi_rd(dha_pkg::ADDR_STATUS);
		chk("indexFault set", 32'h1, rd[7]);
		stall <= 1'b0;
		repeat (PER + 10) @(posedge clk_sys);
		axi_wr(dha_pkg::ADDR_CTRL, BASE | 32'h20);
		axi_rd(dha_pkg::ADDR_STATUS);
		chk("indexFault clear", 32'h0, rd[7]);
		chk("headSettled", 32'h1, rd[1]);
		$display("test index finished");
		// Read with engage dropped: the read alone must hold the head
		axi_wr(dha_pkg::ADDR_CTRL, 32'h0000_0011);
		chk("headLoad reading", 32'h1, headLoad);
		n = 0;
		cnt = 0;
		while (headLoad === 1'b1 && n < 3 * PER) begin
			@(posedge clk_sys);
			n++;
			if (serializer_phase_tagN === 1'b0) begin
				cnt++;
				if (cnt == 1)
					t1 = n;
				if (cnt == 2)
					t2 = n;
			end
		end
		chk("headLoad after", 32'h0, headLoad);
		chk("tag count", 32'h3, cnt);
		chk("tag spacing", dha_pkg::TAG_CYC, t2 - t1);
		axi_rd(dha_pkg::ADDR_DATA);
		chk("word", 32'h0000_FFFF, rd);
		axi_rd(dha_pkg::ADDR_CTRL);
		chk("ctrl after read", 32'h0000_0001, rd);
		axi_wr(dha_pkg::ADDR_CTRL, 32'h0);
		chk("motor off", 32'h0, motorOn);
		$display("test read finished");
		close_out();
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		$display("[FAIL] watchdog expected done seen timeout");
		mismatches++;
		close_out();
	end
endmodule : test_diskette_head_access
